// file: hw/sprcg_consts.svh
`ifndef SPRCG_CONSTS_SVH
`define SPRCG_CONSTS_SVH

// register addresses (byte addresses on the bus, low 16 bits decoded)
`define SPRCG_ADDR_TBIC   16'hf19c
`define SPRCG_ADDR_PMW    16'hfeaa
`define SPRCG_ADDR_TBUF   16'hfeb0
`define SPRCG_ADDR_RBUF   16'hfeb2
`define SPRCG_ADDR_BG     16'hfeb4
`define SPRCG_ADDR_FDV    16'hfeb6
`define SPRCG_ADDR_ABCON  16'hfef8
`define SPRCG_ADDR_AUTOBAUD_STATUS 16'hfefe
`define SPRCG_ADDR_TIC    16'hff6c
`define SPRCG_ADDR_RIC    16'hff6e
`define SPRCG_ADDR_EIC    16'hff70
`define SPRCG_ADDR_CON    16'hffb0
`define SPRCG_ADDR_CLC    16'hffba

`define SPRCG_RESET_VALUE 16'h0000

// clock control field positions
`define SPRCG_CLC_REQ_BIT  0
`define SPRCG_CLC_STS_BIT  1
`define SPRCG_CLC_SUSP_BIT 2
`define SPRCG_CLC_EXT_BIT  3

// stop/start delay counter reload; the gate switches 3 cycles after a stop decision and 4 after a start decision
`define SPRCG_GATE_DELAY   2'd2

`endif

// file: hw/sprcg_pkg.sv
package sprcg_pkg;

    typedef enum logic [1:0] {
        SPRCG_RUN,
        SPRCG_STOPPING,
        SPRCG_OFF,
        SPRCG_STARTING
    } sprcg_gate_e;

    typedef struct packed {
        logic        clock_off_request;
        logic        debug_halt_enable;
        logic        external_off_mask;
    } sprcg_clc_s;

    typedef struct packed {
        logic        we;
        logic [15:0] data;
    } sprcg_hw_upd_s;

endpackage : sprcg_pkg

// file: hw/sprcg_regs.sv
// Behaviour
// - clock control bit 0 is a writable request to switch the module clock off.
// - clock control bit 1 is read-only and reads one while the module clock is off.
// - clock control bit 2 lets a debug suspend request stop the module when set.
// - clock control bit 3 at zero honours external off requests and at one ignores them.
// - main control and both autobaud registers merge software writes and hardware updates.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sprcg_consts.svh"

module sprcg_regs
    import sprcg_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          ext_off_req,
    input  wire logic          debug_suspend_req,
    input  wire sprcg_hw_upd_s hw_main_control,
    input  wire sprcg_hw_upd_s hw_autobaud_control,
    input  wire sprcg_hw_upd_s hw_autobaud_status,
    input  wire sprcg_hw_upd_s hw_receive_buffer,
    output logic               module_clk_en,
    output logic      [15:0]   serial_main_control,
    output logic      [15:0]   autobaud_control,
    output logic      [15:0]   autobaud_status,
    output logic      [15:0]   baud_timer_reload,
    output logic      [15:0]   fractional_divider,
    output logic      [15:0]   infrared_pulse_cfg,
    output logic      [15:0]   transmit_buffer,
    output logic      [15:0]   transmit_irq_ctrl,
    output logic      [15:0]   receive_irq_ctrl,
    output logic      [15:0]   error_irq_ctrl,
    output logic      [15:0]   tx_buffer_irq_ctrl
);

    sprcg_clc_s  clc;
    sprcg_gate_e gate_state;
    logic [1:0]  gate_cnt;
    logic [15:0] receive_buffer;
    logic        ext_sync1;
    logic        ext_sync2;
    logic        dbg_sync1;
    logic        dbg_sync2;
    logic        wr;
    logic        stop_wanted;
    logic        clock_off_status;
    logic        next_clk_en;
    logic        addr_hit;
    logic [15:0] rd_val;

    // merge a 16-bit write honouring byte strobes
    function automatic logic [15:0] sprcg_wmerge(input logic [15:0] old,
                                                input logic [15:0] wd,
                                                input logic [1:0]  st);
        sprcg_wmerge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction : sprcg_wmerge

    function automatic logic sprcg_hit(input logic [31:0] a, input logic [15:0] r);
        sprcg_hit = (a[15:2] == r[15:2]);
    endfunction : sprcg_hit

    // half-word registers share one word; bit 1 picks the lane pair
    function automatic logic [1:0] sprcg_lanes(input logic [31:0] a, input logic [3:0] s);
        sprcg_lanes = a[1] ? s[3:2] : s[1:0];
    endfunction : sprcg_lanes

    logic [15:0] wdat;
    logic [1:0]  wst;

    assign pready  = 1'b1;
    assign wr      = psel && penable && pwrite && !pslverr;
    assign wdat    = paddr[1] ? pwdata[31:16] : pwdata[15:0];
    assign wst     = sprcg_lanes(paddr, pstrb);

    // exact half-word address compare; anything else answers with an error
    always_comb begin
        addr_hit = 1'b1;
        rd_val   = 16'h0000;
        unique case (paddr[15:0])
            `SPRCG_ADDR_CLC:    rd_val = {12'h000, clc.external_off_mask, clc.debug_halt_enable,
                                          clock_off_status, clc.clock_off_request};
            `SPRCG_ADDR_CON:    rd_val = serial_main_control;
            `SPRCG_ADDR_ABCON:  rd_val = autobaud_control;
            `SPRCG_ADDR_AUTOBAUD_STATUS: rd_val = autobaud_status;
            `SPRCG_ADDR_BG:     rd_val = baud_timer_reload;
            `SPRCG_ADDR_FDV:    rd_val = fractional_divider;
            `SPRCG_ADDR_PMW:    rd_val = infrared_pulse_cfg;
            `SPRCG_ADDR_TBUF:   rd_val = transmit_buffer;
            `SPRCG_ADDR_RBUF:   rd_val = receive_buffer;
            `SPRCG_ADDR_TIC:    rd_val = transmit_irq_ctrl;
            `SPRCG_ADDR_RIC:    rd_val = receive_irq_ctrl;
            `SPRCG_ADDR_EIC:    rd_val = error_irq_ctrl;
            `SPRCG_ADDR_TBIC:   rd_val = tx_buffer_irq_ctrl;
            default:            addr_hit = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && (!addr_hit || paddr[31:16] != 16'h0000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= paddr[1] ? {rd_val, 16'h0000} : {16'h0000, rd_val};
        end
    end

    // prdata is captured in setup so it is a flop and valid in the access phase
    // external requests come from another domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            dbg_sync1 <= 1'b0;
            dbg_sync2 <= 1'b0;
        end else begin
            ext_sync1 <= ext_off_req;
            ext_sync2 <= ext_sync1;
            dbg_sync1 <= debug_suspend_req;
            dbg_sync2 <= dbg_sync1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clc <= '0;
        end else if (wr && sprcg_hit(paddr, `SPRCG_ADDR_CLC) && wst[0]) begin
            clc.clock_off_request <= wdat[`SPRCG_CLC_REQ_BIT];
            clc.debug_halt_enable <= wdat[`SPRCG_CLC_SUSP_BIT];
            clc.external_off_mask <= wdat[`SPRCG_CLC_EXT_BIT];
        end
    end

    assign stop_wanted = clc.clock_off_request
                       || (ext_sync2 && !clc.external_off_mask)
                       || (dbg_sync2 && clc.debug_halt_enable);

    // gate sequencer: the status only follows once the gate has really switched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_state <= SPRCG_RUN;
            gate_cnt   <= 2'd0;
        end else begin
            unique case (gate_state)
                SPRCG_RUN: if (stop_wanted) begin
                    gate_state <= SPRCG_STOPPING;
                    gate_cnt   <= `SPRCG_GATE_DELAY;
                end
                SPRCG_STOPPING: if (gate_cnt == 2'd0) begin
                    gate_state <= SPRCG_OFF;
                end else begin
                    gate_cnt <= gate_cnt - 2'd1;
                end
                SPRCG_OFF: if (!stop_wanted) begin
                    gate_state <= SPRCG_STARTING;
                    gate_cnt   <= `SPRCG_GATE_DELAY;
                end
                SPRCG_STARTING: if (gate_cnt == 2'd0) begin
                    gate_state <= SPRCG_RUN;
                end else begin
                    gate_cnt <= gate_cnt - 2'd1;
                end
            endcase
        end
    end

    // clock stays on through the stop delay and stays off until the start delay is over
    assign next_clk_en = (gate_state == SPRCG_RUN) ||
                         (gate_state == SPRCG_STOPPING && gate_cnt != 2'd0);

    // status is the exact inverse of the enable, so it never reads on while the gate is shut
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_clk_en    <= 1'b1;
            clock_off_status <= 1'b0;
        end else begin
            module_clk_en    <= next_clk_en;
            clock_off_status <= !next_clk_en;
        end
    end

    // software and hardware share storage; hardware wins a same-cycle clash
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_main_control <= `SPRCG_RESET_VALUE;
            autobaud_control    <= `SPRCG_RESET_VALUE;
            autobaud_status     <= `SPRCG_RESET_VALUE;
        end else begin
            if (hw_main_control.we) begin
                serial_main_control <= hw_main_control.data;
            end else if (wr && sprcg_hit(paddr, `SPRCG_ADDR_CON)) begin
                serial_main_control <= sprcg_wmerge(serial_main_control, wdat, wst);
            end
            if (hw_autobaud_control.we) begin
                autobaud_control <= hw_autobaud_control.data;
            end else if (wr && sprcg_hit(paddr, `SPRCG_ADDR_ABCON)) begin
                autobaud_control <= sprcg_wmerge(autobaud_control, wdat, wst);
            end
            if (hw_autobaud_status.we) begin
                autobaud_status <= hw_autobaud_status.data;
            end else if (wr && sprcg_hit(paddr, `SPRCG_ADDR_AUTOBAUD_STATUS)) begin
                autobaud_status <= sprcg_wmerge(autobaud_status, wdat, wst);
            end
        end
    end

    // only the serial engine loads it; bus writes fall through
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_buffer <= `SPRCG_RESET_VALUE;
        end else if (hw_receive_buffer.we) begin
            receive_buffer <= hw_receive_buffer.data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_timer_reload  <= `SPRCG_RESET_VALUE;
            fractional_divider <= `SPRCG_RESET_VALUE;
            infrared_pulse_cfg <= `SPRCG_RESET_VALUE;
            transmit_buffer    <= `SPRCG_RESET_VALUE;
            transmit_irq_ctrl  <= `SPRCG_RESET_VALUE;
            receive_irq_ctrl   <= `SPRCG_RESET_VALUE;
            error_irq_ctrl     <= `SPRCG_RESET_VALUE;
            tx_buffer_irq_ctrl <= `SPRCG_RESET_VALUE;
        end else if (wr) begin
            unique case (paddr[15:0])
                `SPRCG_ADDR_BG:   baud_timer_reload  <= sprcg_wmerge(baud_timer_reload, wdat, wst);
                `SPRCG_ADDR_FDV:  fractional_divider <= sprcg_wmerge(fractional_divider, wdat, wst);
                `SPRCG_ADDR_PMW:  infrared_pulse_cfg <= sprcg_wmerge(infrared_pulse_cfg, wdat, wst);
                `SPRCG_ADDR_TBUF: transmit_buffer    <= sprcg_wmerge(transmit_buffer, wdat, wst);
                `SPRCG_ADDR_TIC:  transmit_irq_ctrl  <= sprcg_wmerge(transmit_irq_ctrl, wdat, wst);
                `SPRCG_ADDR_RIC:  receive_irq_ctrl   <= sprcg_wmerge(receive_irq_ctrl, wdat, wst);
                `SPRCG_ADDR_EIC:  error_irq_ctrl     <= sprcg_wmerge(error_irq_ctrl, wdat, wst);
                `SPRCG_ADDR_TBIC: tx_buffer_irq_ctrl <= sprcg_wmerge(tx_buffer_irq_ctrl, wdat, wst);
                default: ;
            endcase
        end
    end

endmodule : sprcg_regs
`default_nettype wire

// file: bench/sprcg_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "sprcg_consts.svh"
module sprcg_regs_assertions
    import sprcg_pkg::*;
(
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [31:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [3:0]    pstrb,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire sprcg_hw_upd_s hw_main_control,
    input wire sprcg_hw_upd_s hw_autobaud_control,
    input wire sprcg_hw_upd_s hw_autobaud_status,
    input wire logic [15:0]   serial_main_control,
    input wire logic [15:0]   autobaud_control,
    input wire logic [15:0]   autobaud_status,
    input wire logic [15:0]   transmit_buffer,
    input wire logic          module_clk_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire        acc = psel && penable;
    wire [15:0] wlo = pwdata[15:0];
    wire [31:0] tb  = {16'h0000, `SPRCG_ADDR_TBUF};
    property p_ready; psel |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low in a transfer");
    property p_unmapped; acc && paddr == 32'h0000fe00 |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped address");
    property p_clc_ok; acc && paddr == {16'h0000, `SPRCG_ADDR_CLC} |-> !pslverr; endproperty
    a_clc_ok: assert property (p_clc_ok) else $error("error on clock control");
    property p_wr; acc && pwrite && paddr == tb && pstrb == 4'hf |=> transmit_buffer == $past(wlo);
    endproperty
    a_wr: assert property (p_wr) else $error("transmit buffer write lost");
    property p_rd; psel && !penable && !pwrite && paddr == tb
        |=> prdata == {16'h0000, $past(transmit_buffer)}; endproperty
    a_rd: assert property (p_rd) else $error("transmit buffer read wrong");
    property p_hw_main; hw_main_control.we |=> serial_main_control == $past(hw_main_control.data);
    endproperty
    a_hw_main: assert property (p_hw_main) else $error("main control update lost");
    property p_hw_abc; hw_autobaud_control.we |=> autobaud_control == $past(hw_autobaud_control.data);
    endproperty
    a_hw_abc: assert property (p_hw_abc) else $error("autobaud control update lost");
    property p_hw_abs; hw_autobaud_status.we |=> autobaud_status == $past(hw_autobaud_status.data);
    endproperty
    a_hw_abs: assert property (p_hw_abs) else $error("autobaud status update lost");
    c_err: cover property (acc && pslverr);
    c_off: cover property ($fell(module_clk_en));
    c_on: cover property ($rose(module_clk_en));
endmodule : sprcg_regs_assertions
`default_nettype wire

// file: bench/sprcg_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module sprcg_engine_model
    import sprcg_pkg::*;
(
    input  wire logic        pclk,
    output var sprcg_hw_upd_s hw_main_control,
    output var sprcg_hw_upd_s hw_autobaud_control,
    output var sprcg_hw_upd_s hw_autobaud_status,
    output var sprcg_hw_upd_s hw_receive_buffer
);
    initial begin
        hw_main_control = '0;
        hw_autobaud_control = '0;
        hw_autobaud_status = '0;
        hw_receive_buffer = '0;
    end
    // one-cycle pulse; data inverted afterwards so a stale value is never mistaken for a hit
    task automatic send(input int sel, input logic [15:0] d);
        @(posedge pclk);
        case (sel)
            0: hw_main_control <= '{1'b1, d};
            1: hw_autobaud_control <= '{1'b1, d};
            2: hw_autobaud_status <= '{1'b1, d};
            default: hw_receive_buffer <= '{1'b1, d};
        endcase
        @(posedge pclk);
        hw_main_control <= '{1'b0, ~d};
        hw_autobaud_control <= '{1'b0, ~d};
        hw_autobaud_status <= '{1'b0, ~d};
        hw_receive_buffer <= '{1'b0, ~d};
    endtask : send
endmodule : sprcg_engine_model
`default_nettype wire

// file: bench/sprcg_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sprcg_consts.svh"
module sprcg_regs_bench
    import sprcg_pkg::*;
;
    logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0]   paddr = '0, pwdata = '0, prdata, rd;
    logic [3:0]    pstrb = 4'hf;
    logic          ext_off_req = 1'b0, debug_suspend_req = 1'b0, pready, pslverr, clk_en, er;
    sprcg_hw_upd_s hm, hac, has, hrb;
    logic [15:0]   o_tbic, o_pmw, o_tbuf, o_bg, o_fdv, o_abc, o_abs, o_tic, o_ric, o_eic, o_con;
    int            bad_count = 0, n_checks = 0;
    logic [15:0]   addrs [13] = '{`SPRCG_ADDR_TBIC, `SPRCG_ADDR_PMW, `SPRCG_ADDR_TBUF,
        `SPRCG_ADDR_RBUF, `SPRCG_ADDR_BG, `SPRCG_ADDR_FDV, `SPRCG_ADDR_ABCON, `SPRCG_ADDR_AUTOBAUD_STATUS,
        `SPRCG_ADDR_TIC, `SPRCG_ADDR_RIC, `SPRCG_ADDR_EIC, `SPRCG_ADDR_CON, `SPRCG_ADDR_CLC};
    logic [15:0]   hwa [4] = '{`SPRCG_ADDR_CON, `SPRCG_ADDR_ABCON, `SPRCG_ADDR_AUTOBAUD_STATUS,
        `SPRCG_ADDR_RBUF};
    localparam logic [15:0] CLC = `SPRCG_ADDR_CLC;
    always #12.5 pclk = ~pclk;
    sprcg_engine_model sprcg_engine_model_inst (.pclk(pclk), .hw_main_control(hm),
        .hw_autobaud_control(hac), .hw_autobaud_status(has), .hw_receive_buffer(hrb));
    sprcg_regs sprcg_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_off_req(ext_off_req),
        .debug_suspend_req(debug_suspend_req), .hw_main_control(hm), .hw_autobaud_control(hac),
        .hw_autobaud_status(has), .hw_receive_buffer(hrb), .module_clk_en(clk_en),
        .serial_main_control(o_con), .autobaud_control(o_abc), .autobaud_status(o_abs),
        .baud_timer_reload(o_bg), .fractional_divider(o_fdv), .infrared_pulse_cfg(o_pmw),
        .transmit_buffer(o_tbuf), .transmit_irq_ctrl(o_tic), .receive_irq_ctrl(o_ric),
        .error_irq_ctrl(o_eic), .tx_buffer_irq_ctrl(o_tbic));
    function automatic logic [31:0] lane(input logic [15:0] a, input logic [15:0] v);
        return a[1] ? {v, 16'h0000} : {16'h0000, v};
    endfunction : lane
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] v);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {16'h0000, a};
        pwdata <= {v, v};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) bad_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : acc
    task automatic rdchk(input string nm, input logic [15:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        chk(nm, lane(a, e), rd);
    endtask : rdchk
    task automatic wait_en(input logic v);
        int n;
        n = 0;
        while (clk_en !== v && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk("module_clk_en", {31'h0, v}, {31'h0, clk_en});
    endtask : wait_en
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (addrs[i]) rdchk("reset value", addrs[i], 16'h0000);
        $display("test reset done");
        foreach (addrs[i]) if (addrs[i] != CLC) acc(1'b1, addrs[i], 16'ha500 + 16'(i));
        foreach (addrs[i]) if (addrs[i] != CLC) rdchk("readback", addrs[i],
            (addrs[i] == `SPRCG_ADDR_RBUF) ? 16'h0000 : 16'ha500 + 16'(i));
        chk("port tbic", 32'h0000a500, {16'h0000, o_tbic});
        chk("port pmw", 32'h0000a501, {16'h0000, o_pmw});
        chk("port tbuf", 32'h0000a502, {16'h0000, o_tbuf});
        chk("port bg", 32'h0000a504, {16'h0000, o_bg});
        chk("port fdv", 32'h0000a505, {16'h0000, o_fdv});
        chk("port abc", 32'h0000a506, {16'h0000, o_abc});
        chk("port abs", 32'h0000a507, {16'h0000, o_abs});
        chk("port tic", 32'h0000a508, {16'h0000, o_tic});
        chk("port ric", 32'h0000a509, {16'h0000, o_ric});
        chk("port eic", 32'h0000a50a, {16'h0000, o_eic});
        chk("port con", 32'h0000a50b, {16'h0000, o_con});
        pstrb <= 4'h1;
        acc(1'b1, `SPRCG_ADDR_TBUF, 16'h3c3c);
        pstrb <= 4'hf;
        rdchk("byte strobe", `SPRCG_ADDR_TBUF, 16'ha53c);
        acc(1'b1, 16'hfe00, 16'h1234);
        chk("unmapped err", 32'h1, {31'h0, er});
        rdchk("unmapped", 16'hfe00, 16'h0000);
        $display("test access done");
        acc(1'b1, CLC, 16'hffff);
        wait_en(1'b0);
        rdchk("clc off", CLC, 16'h000f);
        acc(1'b1, CLC, 16'h0000);
        wait_en(1'b1);
        rdchk("clc on", CLC, 16'h0000);
        ext_off_req <= 1'b1;
        wait_en(1'b0);
        rdchk("clc ext", CLC, 16'h0002);
        acc(1'b1, CLC, 16'h0008);
        wait_en(1'b1);
        debug_suspend_req <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("no suspend", 32'h1, {31'h0, clk_en});
        acc(1'b1, CLC, 16'h000c);
        wait_en(1'b0);
        rdchk("clc dbg", CLC, 16'h000e);
        ext_off_req <= 1'b0;
        debug_suspend_req <= 1'b0;
        wait_en(1'b1);
        $display("test clock gate done");
        for (int k = 0; k < 4; k++) begin
            sprcg_engine_model_inst.send(k, 16'h1350 + 16'(k));
            rdchk("hw update", hwa[k], 16'h1350 + 16'(k));
        end
        acc(1'b1, `SPRCG_ADDR_RBUF, 16'hffff);
        rdchk("rbuf kept", `SPRCG_ADDR_RBUF, 16'h1353);
        $display("test hardware update done");
        conclude();
    end
    initial begin
        #500000;
        bad_count++;
        conclude();
    end
endmodule : sprcg_regs_bench
bind sprcg_regs sprcg_regs_assertions sprcg_regs_assertions_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_main_control(hw_main_control), .hw_autobaud_control(hw_autobaud_control),
    .hw_autobaud_status(hw_autobaud_status), .serial_main_control(serial_main_control),
    .autobaud_control(autobaud_control), .autobaud_status(autobaud_status),
    .transmit_buffer(transmit_buffer), .module_clk_en(module_clk_en));
`default_nettype wire
